// File: verilog/cfm_regs.svh
// timing constants and setting limits for the contactor feedback monitor
// assumes a single 25 MHz reference clock
`ifndef CFM_REGS_SVH
`define CFM_REGS_SVH

// reference clock rate
`define CFM_CLK_HZ          25000000
// delay measurement resolution, in ms
`define CFM_STEP_MS         10
// logic execution cycle, in ms
`define CFM_CYCLE_MS        4
// clock cycles per resolution step and per logic cycle
`define CFM_STEP_CLKS       ((`CFM_CLK_HZ / 1000) * `CFM_STEP_MS)
`define CFM_CYCLE_CLKS      ((`CFM_CLK_HZ / 1000) * `CFM_CYCLE_MS)
// width of the divider counters
`define CFM_DIV_W           18

// max feedback delay setting, in 10 ms steps
`define CFM_DELAY_W         7
`define CFM_DELAY_MIN_MS    10
`define CFM_DELAY_MAX_MS    1000
`define CFM_DELAY_MIN_STEPS 7'h01
`define CFM_DELAY_MAX_STEPS 7'h64

`endif

// File: verilog/cfm_pkg.sv
// types shared by the contactor feedback monitor modules
// assumes cfm_regs.svh for the numeric constants
`include "cfm_regs.svh"

package cfm_pkg;

    // monitor state, one-hot
    typedef enum logic [2:0] {
        CFM_ST_IDLE   = 3'h1,
        CFM_ST_ACTIVE = 3'h2,
        CFM_ST_FAULT  = 3'h4
    } cfm_state_e;

    typedef logic [`CFM_DELAY_W-1:0] cfm_delay_t;
    typedef logic [`CFM_DIV_W-1:0]   cfm_div_t;

endpackage : cfm_pkg

// File: verilog/cfm_tick_if.sv
// carrier for the timing enables between divider and monitor
// assumes both ends run on the same reference clock
`timescale 1ns/100ps

interface cfm_tick_if;
    logic cyc_en;
    logic step_en;

    modport src
    (
        output cyc_en,
        output step_en
    );

    modport snk
    (
        input  cyc_en,
        input  step_en
    );
endinterface : cfm_tick_if

// File: verilog/cfm_tick_div.sv
// divider making the logic cycle enable and the 10 ms step enable
// assumes one clock; enables are single-cycle pulses
`timescale 1ns/100ps
`include "cfm_regs.svh"

module cfm_tick_div
    import cfm_pkg::*;
#(
    parameter int CYC_CLKS  = `CFM_CYCLE_CLKS,
    parameter int STEP_CLKS = `CFM_STEP_CLKS
)
(
    input  wire logic   i_ref_clk,
    input  wire logic   i_resetn,
    cfm_tick_if.src     tick
);

    cfm_div_t cyc_cnt_q;
    cfm_div_t cyc_cnt_d;
    cfm_div_t step_cnt_q;
    cfm_div_t step_cnt_d;
    logic     cyc_en_q;
    logic     cyc_en_d;
    logic     step_en_q;
    logic     step_en_d;

    always_comb
    begin
        cyc_en_d  = 1'b0;
        step_en_d = 1'b0;
        cyc_cnt_d  = cyc_cnt_q + cfm_div_t'(1);
        step_cnt_d = step_cnt_q + cfm_div_t'(1);
        if (cyc_cnt_q >= cfm_div_t'(CYC_CLKS - 1))
        begin
            cyc_cnt_d = '0;
            cyc_en_d  = 1'b1;
        end
        if (step_cnt_q >= cfm_div_t'(STEP_CLKS - 1))
        begin
            step_cnt_d = '0;
            step_en_d  = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            cyc_cnt_q  <= '0;
            step_cnt_q <= '0;
            cyc_en_q   <= 1'b0;
            step_en_q  <= 1'b0;
        end
        else
        begin
            cyc_cnt_q  <= cyc_cnt_d;
            step_cnt_q <= step_cnt_d;
            cyc_en_q   <= cyc_en_d;
            step_en_q  <= step_en_d;
        end
    end

    assign tick.cyc_en  = cyc_en_q;
    assign tick.step_en = step_en_q;

endmodule : cfm_tick_div

// File: verilog/cfm_monitor.sv
// contactor feedback monitor: drives a switching element from a demand
// input and checks that the element's feedback follows inverted in time
// assumes all inputs synchronous to i_ref_clk; no software registers
//
// Behaviour
// - both switching outputs always equal
// - feedback high then demand rise: outputs high
// - demand low or error: outputs low
// - demand rise with feedback low: error
// - after rise, feedback must fall in time
// - after fall, feedback must rise in time
// - demand low, feedback low too long: error
// - demand high, feedback high too long: error
// - valid switch-on sequence clears the error
// - error-reset rise clears on valid levels
// - that reset turns outputs on if demand high
// - delay setting 10 to 1000 ms, 10 ms steps
`timescale 1ns/100ps
`include "cfm_regs.svh"

module cfm_monitor
    import cfm_pkg::*;
#(
    parameter int CYC_CLKS  = `CFM_CYCLE_CLKS,
    parameter int STEP_CLKS = `CFM_STEP_CLKS
)
(
    input  wire logic                    i_ref_clk,
    input  wire logic                    i_resetn,
    input  wire logic                    i_demand,
    input  wire logic                    i_feedback,
    input  wire logic                    i_err_reset,
    input  wire logic                    i_err_reset_en,
    input  wire logic                    i_fault_present_en,
    input  wire logic [`CFM_DELAY_W-1:0] i_max_feedback_delay,
    output logic                         o_out1,
    output logic                         o_out2,
    output logic                         o_monitor_error,
    output logic                         o_fault_present,
    output logic                         o_cycle_tick
);

    // logic cycle and 10 ms step enables
    cfm_tick_if tick ();

    cfm_tick_div #(
        .CYC_CLKS  (CYC_CLKS),
        .STEP_CLKS (STEP_CLKS)
    ) u_tick_div (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .tick      (tick)
    );

    // clamp the delay setting into its legal range
    function automatic cfm_delay_t clamp_delay(input cfm_delay_t v);
        cfm_delay_t r;
        r = v;
        if (v < `CFM_DELAY_MIN_STEPS)
        begin
            r = `CFM_DELAY_MIN_STEPS;
        end
        else if (v > `CFM_DELAY_MAX_STEPS)
        begin
            r = `CFM_DELAY_MAX_STEPS;
        end
        return r;
    endfunction : clamp_delay

    // sampled inputs, previous cycle's values
    logic       dem_q;
    logic       dem_d;
    logic       fb_q;
    logic       fb_d;
    logic       rst_q;
    logic       rst_d;
    cfm_delay_t lim_q;
    cfm_delay_t lim_d;

    // mismatch timer in 10 ms steps
    cfm_delay_t tmr_q;
    cfm_delay_t tmr_d;

    cfm_state_e state_q;
    cfm_state_e state_d;
    logic       out_q;
    logic       out_d;
    logic       err_q;
    logic       err_d;
    logic       flt_q;
    logic       flt_d;
    logic       cyc_q;
    logic       cyc_d;

    logic dem_rise;
    logic dem_fall;
    logic mismatch;
    logic timeout;
    logic rst_rise;
    logic rst_off_ok;
    logic rst_on_ok;

    always_comb
    begin
        dem_rise   = i_demand & ~dem_q;
        dem_fall   = ~i_demand & dem_q;
        rst_rise   = i_err_reset_en & i_err_reset & ~rst_q;
        rst_off_ok = ~i_demand & i_feedback;
        rst_on_ok  = i_demand & ~i_feedback;
        // feedback should be the inverse of the demand
        mismatch   = (dem_q == fb_q);
        timeout    = mismatch && (tmr_q >= lim_q);
    end

    // input sampling once per logic cycle
    always_comb
    begin
        dem_d = dem_q;
        fb_d  = fb_q;
        rst_d = rst_q;
        lim_d = lim_q;
        if (tick.cyc_en)
        begin
            dem_d = i_demand;
            fb_d  = i_feedback;
            rst_d = i_err_reset;
            lim_d = clamp_delay(i_max_feedback_delay);
        end
    end

    // feedback delay timer: runs while feedback equals demand
    always_comb
    begin
        tmr_d = tmr_q;
        if (tick.cyc_en && (dem_rise || dem_fall))
        begin
            tmr_d = '0;
        end
        else if (!mismatch)
        begin
            tmr_d = '0;
        end
        // saturate so the count never wraps back under the limit
        else if (tick.step_en && (tmr_q != `CFM_DELAY_MAX_STEPS))
        begin
            tmr_d = tmr_q + cfm_delay_t'(1);
        end
    end

    // monitor state, evaluated once per logic cycle
    always_comb
    begin
        state_d = state_q;
        if (tick.cyc_en)
        begin
            case (state_q)
                CFM_ST_IDLE:
                begin
                    if (dem_rise && !i_feedback)
                    begin
                        state_d = CFM_ST_FAULT;
                    end
                    else if (dem_rise)
                    begin
                        state_d = CFM_ST_ACTIVE;
                    end
                    else if (timeout)
                    begin
                        state_d = CFM_ST_FAULT;
                    end
                end
                CFM_ST_ACTIVE:
                begin
                    if (!i_demand)
                    begin
                        state_d = CFM_ST_IDLE;
                    end
                    else if (timeout)
                    begin
                        state_d = CFM_ST_FAULT;
                    end
                end
                CFM_ST_FAULT:
                begin
                    if (dem_rise && i_feedback)
                    begin
                        state_d = CFM_ST_ACTIVE;
                    end
                    else if (rst_rise && rst_on_ok)
                    begin
                        state_d = CFM_ST_ACTIVE;
                    end
                    else if (rst_rise && rst_off_ok)
                    begin
                        state_d = CFM_ST_IDLE;
                    end
                end
                default:
                begin
                    state_d = CFM_ST_FAULT;
                end
            endcase
            // an idle or lingering mismatch still counts as a fault;
            // a new error wins over any clearing in the same cycle
            if (timeout && !(dem_rise || dem_fall))
            begin
                state_d = CFM_ST_FAULT;
            end
            if (dem_rise && !i_feedback)
            begin
                state_d = CFM_ST_FAULT;
            end
        end
    end

    // registered outputs follow the next state
    always_comb
    begin
        out_d = (state_d == CFM_ST_ACTIVE);
        err_d = (state_d == CFM_ST_FAULT);
        // fault flag is the error gated by its enable
        flt_d = err_d & i_fault_present_en;
        cyc_d = tick.cyc_en;
    end

    // sampled inputs and delay limit
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            // err_reset starts high so a held reset gives no edge
            dem_q <= 1'b0;
            fb_q  <= 1'b1;
            rst_q <= 1'b1;
            lim_q <= `CFM_DELAY_MAX_STEPS;
        end
        else
        begin
            dem_q <= dem_d;
            fb_q  <= fb_d;
            rst_q <= rst_d;
            lim_q <= lim_d;
        end
    end

    // mismatch timer
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            tmr_q <= '0;
        end
        else
        begin
            tmr_q <= tmr_d;
        end
    end

    // monitor state
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state_q <= CFM_ST_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // registered outputs and cycle tick
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            out_q <= 1'b0;
            err_q <= 1'b0;
            flt_q <= 1'b0;
            cyc_q <= 1'b0;
        end
        else
        begin
            out_q <= out_d;
            err_q <= err_d;
            flt_q <= flt_d;
            cyc_q <= cyc_d;
        end
    end

    // one register feeds both switching outputs
    assign o_out1          = out_q;
    assign o_out2          = out_q;
    assign o_monitor_error = err_q;
    assign o_fault_present = flt_q;
    assign o_cycle_tick    = cyc_q;

endmodule : cfm_monitor

// File: sim/cfm_contactor_model.sv
// contactor model: feedback contact opens while the coil is driven
// assumes coil and stuck control come from the monitor clock domain
`timescale 1ns/100ps
module cfm_contactor_model #(parameter int LAG = 30)
(
    input  wire logic i_ref_clk,
    input  wire logic i_coil,
    input  wire logic i_stuck,
    input  wire logic i_release,
    output logic      o_feedback
);
    int cnt = 0;
    initial o_feedback = 1'b1;
    // contact follows the coil inverted after a lag; stuck holds it
    always @(posedge i_ref_clk)
    begin
        // release closes the contact whatever the coil does
        if (i_release)
        begin
            cnt        <= 0;
            o_feedback <= 1'b1;
        end
        else if (i_stuck || (o_feedback != i_coil))
            cnt <= 0;
        else if (cnt < LAG)
            cnt <= cnt + 1;
        else
            o_feedback <= ~i_coil;
    end
endmodule : cfm_contactor_model

// File: sim/cfm_monitor_checker.sv
// port assertions for the contactor feedback monitor
// assumes demand changes only just after a logic cycle
`timescale 1ns/100ps
module cfm_monitor_checker #(parameter int CYC_CLKS = 20)
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_demand,
    input wire logic i_feedback,
    input wire logic i_fault_present_en,
    input wire logic o_out1,
    input wire logic o_out2,
    input wire logic o_monitor_error,
    input wire logic o_fault_present,
    input wire logic o_cycle_tick
);
    localparam int CP = CYC_CLKS;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_resetn);
    a_outs_equal: assert property (o_out1 == o_out2)
        else $error("switching outputs differ");
    a_out_no_err: assert property (o_out1 |-> !o_monitor_error)
        else $error("output on while error");
    a_off_demand_low: assert property
        (o_cycle_tick && !$past(i_demand) |-> !o_out1)
        else $error("output on with demand low");
    a_on_with_demand: assert property
        ($rose(o_out1) |-> $past(i_demand) && o_cycle_tick)
        else $error("output on without demand");
    a_tick_period: assert property
        (o_cycle_tick |-> ##[CP:CP] o_cycle_tick)
        else $error("logic cycle spacing wrong");
    a_change_at_tick: assert property
        ($changed(o_out1) || $changed(o_monitor_error) |-> o_cycle_tick)
        else $error("output changed between cycles");
    a_fault_follows: assert property
        (i_fault_present_en |-> o_fault_present == o_monitor_error)
        else $error("fault flag differs from error");
    a_clear_valid: assert property
        ($fell(o_monitor_error) |-> $past(i_demand) || $past(i_feedback))
        else $error("error cleared on bad levels");
    c_on: cover property ($rose(o_out1));
    c_err: cover property ($rose(o_monitor_error));
    c_clr: cover property ($fell(o_monitor_error));
endmodule : cfm_monitor_checker

bind cfm_monitor cfm_monitor_checker #(.CYC_CLKS(CYC_CLKS)) cfm_checker_i
(
    .i_ref_clk, .i_resetn, .i_demand, .i_feedback, .i_fault_present_en,
    .o_out1, .o_out2, .o_monitor_error, .o_fault_present, .o_cycle_tick
);

// File: sim/contactor_feedback_monitor_test.sv
// self-checking bench for the contactor feedback monitor
// assumes shortened cycle and step counts for simulation
`timescale 1ns/100ps
module contactor_feedback_monitor_test;
    import cfm_pkg::*;
    logic       clk;
    logic       resetn;
    logic       dem;
    logic       fb;
    logic       stuck;
    logic       drop;
    logic       erst;
    logic       erst_en;
    logic       fault_en;
    logic       out1;
    logic       out2;
    logic       err;
    logic       fault;
    logic       tick;
    cfm_delay_t delay;
    int         err_count = 0;
    int         check_count = 0;
    int         cycles = 0;

    cfm_monitor #(.CYC_CLKS(20), .STEP_CLKS(50)) cfm_monitor_i
    (
        .i_ref_clk            (clk),
        .i_resetn             (resetn),
        .i_demand             (dem),
        .i_feedback           (fb),
        .i_err_reset          (erst),
        .i_err_reset_en       (erst_en),
        .i_fault_present_en   (fault_en),
        .i_max_feedback_delay (delay),
        .o_out1               (out1),
        .o_out2               (out2),
        .o_monitor_error      (err),
        .o_fault_present      (fault),
        .o_cycle_tick         (tick)
    );
    cfm_contactor_model #(.LAG(30)) cfm_contactor_model_i
    (
        .i_ref_clk  (clk),
        // coil hangs straight on the output; any delay goes before demand
        .i_coil     (out1),
        .i_stuck    (stuck),
        .i_release  (drop),
        .o_feedback (fb)
    );

    task automatic chk(input string what, input logic seen, input logic exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %b seen %b", what, exp, seen);
        end
    endtask : chk

    task automatic wt(input int n);
        repeat (n) @(posedge tick);
        #1;
    endtask : wt

    task t_normal;
        dem = 1'b1;
        wt(1);
        chk("out1", out1, 1'b1);
        chk("out2", out2, 1'b1);
        wt(10);
        chk("error", err, 1'b0);
        dem = 1'b0;
        wt(1);
        chk("out1", out1, 1'b0);
        wt(10);
        chk("error", err, 1'b0);
        $display("test normal done");
    endtask : t_normal

    task t_stuck_on;
        stuck = 1'b1;
        dem = 1'b1;
        wt(11);
        chk("error", err, 1'b1);
        chk("fault", fault, 1'b1);
        chk("out1", out1, 1'b0);
        stuck = 1'b0;
        dem = 1'b0;
        wt(3);
        chk("error", err, 1'b1);
        dem = 1'b1;
        wt(1);
        chk("error", err, 1'b0);
        chk("out1", out1, 1'b1);
        dem = 1'b0;
        wt(10);
        $display("test stuck on done");
    endtask : t_stuck_on

    task t_stuck_off;
        dem = 1'b1;
        wt(10);
        stuck = 1'b1;
        dem = 1'b0;
        wt(11);
        chk("error", err, 1'b1);
        dem = 1'b1;
        wt(1);
        chk("error", err, 1'b1);
        chk("out1", out1, 1'b0);
        erst_en = 1'b1;
        erst = 1'b1;
        wt(1);
        chk("error", err, 1'b0);
        chk("out1", out1, 1'b1);
        stuck = 1'b0;
        erst = 1'b0;
        dem = 1'b0;
        wt(10);
        chk("error", err, 1'b0);
        $display("test stuck off done");
    endtask : t_stuck_off

    task t_drop_out;
        fault_en = 1'b0;
        dem = 1'b1;
        wt(5);
        chk("out1", out1, 1'b1);
        drop = 1'b1;
        wt(6);
        chk("error", err, 1'b1);
        chk("fault", fault, 1'b0);
        chk("out2", out2, 1'b0);
        drop = 1'b0;
        dem = 1'b0;
        erst_en = 1'b0;
        erst = 1'b1;
        wt(3);
        chk("error", err, 1'b1);
        erst = 1'b0;
        wt(1);
        erst_en = 1'b1;
        erst = 1'b1;
        wt(1);
        chk("error", err, 1'b0);
        chk("out1", out1, 1'b0);
        erst = 1'b0;
        fault_en = 1'b1;
        $display("test drop out done");
    endtask : t_drop_out

    task t_early_low;
        dem = 1'b1;
        wt(3);
        stuck = 1'b1;
        dem = 1'b0;
        wt(1);
        chk("out1", out1, 1'b0);
        dem = 1'b1;
        wt(1);
        chk("error", err, 1'b1);
        chk("fault", fault, 1'b1);
        chk("out1", out1, 1'b0);
        stuck = 1'b0;
        dem = 1'b0;
        wt(4);
        dem = 1'b1;
        wt(1);
        chk("error", err, 1'b0);
        chk("out2", out2, 1'b1);
        $display("test early low done");
    endtask : t_early_low

    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            err_count++;
            end_of_test();
        end
    end

    initial
    begin
        resetn = 1'b0;
        dem = 1'b0;
        stuck = 1'b0;
        drop = 1'b0;
        erst = 1'b0;
        erst_en = 1'b0;
        fault_en = 1'b1;
        // five logic cycles, well above one cycle
        delay = 7'h02;
        repeat (6) @(posedge clk);
        #1;
        resetn = 1'b1;
        t_normal();
        t_stuck_on();
        t_stuck_off();
        t_drop_out();
        t_early_low();
        end_of_test();
    end
endmodule : contactor_feedback_monitor_test
